// *** shared/dlr_pkg.sv ***
// Shared constants and types for the link, equalizer and back-channel register group
package dlr_pkg;
	// Register offsets
	localparam logic [7:0] OFS_EQ_CTL   = 8'h35;
	localparam logic [7:0] OFS_STRAP    = 8'h37;
	localparam logic [7:0] OFS_MCLK     = 8'h3A;
	localparam logic [7:0] OFS_EQ_STATE = 8'h3B;
	localparam logic [7:0] OFS_LINK     = 8'h41;
	localparam logic [7:0] OFS_HSCC     = 8'h43;
	localparam logic [7:0] OFS_FLOOR    = 8'h45;
	// Field positions
	localparam int EQ_RESTART_BIT  = 6;
	localparam int FLOOR_OVR_BIT   = 5;
	localparam int FLOOR_APPLY_BIT = 4;
	localparam int ONE_DONE_BIT    = 7;
	localparam int ONE_LSB         = 4;
	localparam int ZERO_DONE_BIT   = 3;
	localparam int ZERO_LSB        = 0;
	localparam int ODIV_OVR_BIT    = 7;
	localparam int ODIV_LSB        = 4;
	localparam int IDIV_OVR_BIT    = 2;
	localparam int IDIV_LSB        = 0;
	localparam int LINK_EN_BIT     = 4;
	localparam int LINK_THR_LSB    = 0;
	localparam int MISO_MODE_BIT   = 4;
	localparam int CPOL_BIT        = 3;
	localparam int BC_MODE_LSB     = 0;
	localparam int FLOOR_LSB       = 0;
	// Reset values and writable masks
	localparam logic [7:0] EQ_CTL_RST = 8'h00;
	localparam logic [7:0] MCLK_RST   = 8'h00;
	localparam logic [7:0] MCLK_WMASK = 8'hF7;
	localparam logic [7:0] LINK_RST   = 8'h03;
	localparam logic [7:0] HSCC_RST   = 8'h00;
	localparam logic [7:0] FLOOR_RST  = 8'h88;
	// Strap settle time before the decode is latched
	localparam int CLK_PERIOD_NS    = 50;
	localparam int STRAP_SETTLE_NS  = 2000;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Back-channel mode codes
	typedef enum logic [2:0] {
		BC_NORM_GPIO    = 3'h0,
		BC_HS_GPIO1     = 3'h1,
		BC_HS_GPIO2     = 3'h2,
		BC_HS_GPIO4     = 3'h3,
		BC_NORM_FWD_SPI = 3'h4,
		BC_NORM_REV_SPI = 3'h5,
		BC_HS_FWD_SPI   = 3'h6,
		BC_HS_REV_SPI   = 3'h7
	} dlr_bc_mode_e;
	// Strap decode sequence
	typedef enum logic [1:0] {STRAP_SETTLE, STRAP_ZERO, STRAP_ONE, STRAP_IDLE} dlr_strap_e;
	// Register request from the host side
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dlr_reg_req_s;
	// Decoded back-channel mode
	typedef struct packed {
		logic       high_speed;
		logic       spi_mode;
		logic       spi_reverse;
		logic [2:0] gpio_lanes;
	} dlr_bc_dec_s;
	// Divider state
	typedef struct packed {
		logic [4:0] cnt;
		logic       pulse;
	} dlr_div_s;
	// Register group state
	typedef struct packed {
		logic [7:0] eq_ctl;
		logic [7:0] mclk;
		logic [7:0] link;
		logic [7:0] hscc;
		logic [7:0] floor;
		logic [2:0] strap_one;
		logic [2:0] strap_zero;
		logic       one_done;
		logic       zero_done;
		dlr_strap_e strap_st;
		logic [5:0] settle_cnt;
		logic       restart_d;
		logic [1:0] restart_pls;
		logic [7:0] rdata;
		logic       ack;
		logic       lock;
		logic [3:0] err_cnt;
		logic       sclk_d;
		logic       launch;
		logic       sample;
		logic       miso;
		logic       miso_oe_n;
	} dlr_state_s;
endpackage

// *** design/dlr_pow2_div.sv ***
// Power-of-two divider producing one-cycle enable pulses from an input tick
`timescale 1ns/1ns
module dlr_pow2_div (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// Tick in, ratio exponent, divided pulse out
	input  wire logic       tick_i,
	input  wire logic [2:0] exp_i,
	output logic            pulse_o
);
	dlr_pkg::dlr_div_s st_r;
	dlr_pkg::dlr_div_s st_nxt;
	logic [5:0]        limit;

	// Last count before wrap; exponent zero passes every tick
	assign limit = (6'h01 << exp_i) - 6'h01;

	// Count input ticks and wrap at the selected ratio
	always_comb begin
		st_nxt = st_r;
		st_nxt.pulse = 1'b0;
		if (tick_i) begin
			if ({1'b0, st_r.cnt} >= limit) begin
				st_nxt.cnt = 5'h00;
				st_nxt.pulse = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 5'h01;
			end
		end
	end

	// Register the state
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pulse_o = st_r.pulse;
endmodule

// *** design/dlr_regs.sv ***
// Link, equalizer, strap, audio clock divider and back-channel register group
// Summary of operation
// - Restart bit restarts equalizer adaptation from start
// - Restart acts on both receive ports together
// - Floor apply ignored without floor override enable
// - Override plus apply uses stored floor value
// - Each strap sets done flag once latched
// - Strap one upper field, strap zero lower
// - Output divider follows register only when overridden
// - Output code selects divide 32 down to 1
// - Input divider follows register only when overridden
// - Input code divides reference by 1,2,4,8
// - Enable bit turns link error counting on
// - Error counter on pixel rate, threshold resets 3
// - Both clock channels and data channel checked
// - Counting enabled: lock lost at threshold
// - Counting disabled: lock lost at first error
// - Reverse SPI: with MISO mode bit set, output tristated unless slave selected
// - Polarity bit chooses launch and sample edges
// - Mode codes 000 to 011 select GPIO modes
// - Mode codes 100 to 111 select SPI modes
// - Applied floor is 4-bit preset, reset 8
`timescale 1ns/1ns
module dlr_regs (
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	// Register port
	input  wire dlr_pkg::dlr_reg_req_s reg_req_i,
	output logic [7:0]                reg_rdata_o,
	output logic                      reg_ack_o,
	// Port select for register access
	input  wire logic                 port_one_access_select_i,
	// Equalizer
	input  wire logic [5:0]           equalizer_state_p0_i,
	input  wire logic [5:0]           equalizer_state_p1_i,
	output logic [1:0]                equalizer_restart_o,
	output logic                      floor_active_o,
	output logic [3:0]                equalizer_start_level_o,
	// Strap inputs
	input  wire logic [2:0]           strap_zero_level_i,
	input  wire logic [2:0]           strap_one_level_i,
	// Audio master clock divider
	input  wire logic                 ref_tick_i,
	input  wire logic [2:0]           pll_output_code_i,
	input  wire logic [1:0]           pll_input_code_i,
	output logic                      osc_tick_o,
	output logic                      mclk_tick_o,
	// Link integrity
	input  wire logic                 pix_tick_i,
	input  wire logic                 err_clk0_i,
	input  wire logic                 err_clk1_i,
	input  wire logic                 err_data_channel_i,
	input  wire logic                 link_acquire_i,
	output logic                      link_lock_o,
	// Back channel and SPI
	input  wire logic                 spi_sclk_i,
	input  wire logic                 spi_ss_n_i,
	input  wire logic                 spi_miso_data_i,
	output dlr_pkg::dlr_bc_dec_s      bc_mode_o,
	output logic                      spi_launch_o,
	output logic                      spi_sample_o,
	output logic                      spi_miso_o,
	output logic                      spi_miso_oe_n_o
);
	dlr_pkg::dlr_state_s   st_r;
	dlr_pkg::dlr_state_s   st_nxt;
	dlr_pkg::dlr_bc_mode_e bc_mode;
	dlr_pkg::dlr_bc_dec_s  bc_dec;
	logic [2:0]            odiv_code;
	logic [1:0]            idiv_code;
	logic [2:0]            odiv_exp;
	logic                  floor_on;
	logic                  link_err;
	logic [4:0]            err_inc;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  launch_edge;
	logic                  sample_edge;
	logic                  osc_tick;

	// Floor only takes effect with both bits set, else adaptation starts at zero
	assign floor_on = st_r.eq_ctl[dlr_pkg::FLOOR_OVR_BIT]
		& st_r.eq_ctl[dlr_pkg::FLOOR_APPLY_BIT];
	assign floor_active_o = floor_on;
	assign equalizer_start_level_o = floor_on
		? st_r.floor[dlr_pkg::FLOOR_LSB +: 4] : 4'h0;
	assign equalizer_restart_o = st_r.restart_pls;

	// Divider codes come from the register only while overridden
	assign odiv_code = st_r.mclk[dlr_pkg::ODIV_OVR_BIT]
		? st_r.mclk[dlr_pkg::ODIV_LSB +: 3] : pll_output_code_i;
	assign idiv_code = st_r.mclk[dlr_pkg::IDIV_OVR_BIT]
		? st_r.mclk[dlr_pkg::IDIV_LSB +: 2] : pll_input_code_i;

	// Output code to ratio exponent: 32,16,8,4,2,2,1,1
	always_comb begin
		case (odiv_code)
			3'h0:    odiv_exp = 3'h5;
			3'h1:    odiv_exp = 3'h4;
			3'h2:    odiv_exp = 3'h3;
			3'h3:    odiv_exp = 3'h2;
			3'h4,
			3'h5:    odiv_exp = 3'h1;
			default: odiv_exp = 3'h0;
		endcase
	end

	// Reference into the oscillator, divided by 2 to the code
	dlr_pow2_div u_in_div (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.tick_i    (ref_tick_i),
		.exp_i     ({1'b0, idiv_code}),
		.pulse_o   (osc_tick)
	);

	// Oscillator output divided down to the audio master clock rate
	dlr_pow2_div u_out_div (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.tick_i    (osc_tick),
		.exp_i     (odiv_exp),
		.pulse_o   (mclk_tick_o)
	);
	assign osc_tick_o = osc_tick;

	// Any of the two clock channels or the data channel flags an error
	assign link_err = pix_tick_i
		& (err_clk0_i | err_clk1_i | err_data_channel_i);
	assign err_inc = {1'b0, st_r.err_cnt} + 5'h01;

	// Back-channel mode decode
	assign bc_mode = dlr_pkg::dlr_bc_mode_e'(st_r.hscc[dlr_pkg::BC_MODE_LSB +: 3]);
	always_comb begin
		bc_dec = '0;
		case (bc_mode)
			dlr_pkg::BC_NORM_GPIO: bc_dec.gpio_lanes = 3'h1;
			dlr_pkg::BC_HS_GPIO1: begin
				bc_dec.high_speed = 1'b1;
				bc_dec.gpio_lanes = 3'h1;
			end
			dlr_pkg::BC_HS_GPIO2: begin
				bc_dec.high_speed = 1'b1;
				bc_dec.gpio_lanes = 3'h2;
			end
			dlr_pkg::BC_HS_GPIO4: begin
				bc_dec.high_speed = 1'b1;
				bc_dec.gpio_lanes = 3'h4;
			end
			dlr_pkg::BC_NORM_FWD_SPI: bc_dec.spi_mode = 1'b1;
			dlr_pkg::BC_NORM_REV_SPI: begin
				bc_dec.spi_mode = 1'b1;
				bc_dec.spi_reverse = 1'b1;
			end
			dlr_pkg::BC_HS_FWD_SPI: begin
				bc_dec.high_speed = 1'b1;
				bc_dec.spi_mode = 1'b1;
			end
			dlr_pkg::BC_HS_REV_SPI: begin
				bc_dec.high_speed = 1'b1;
				bc_dec.spi_mode = 1'b1;
				bc_dec.spi_reverse = 1'b1;
			end
			default: bc_dec = '0;
		endcase
	end
	assign bc_mode_o = bc_dec;

	// Serial clock edges; polarity zero launches on fall, samples on rise
	assign sclk_rise = spi_sclk_i & ~st_r.sclk_d;
	assign sclk_fall = ~spi_sclk_i & st_r.sclk_d;
	assign launch_edge = st_r.hscc[dlr_pkg::CPOL_BIT] ? sclk_rise : sclk_fall;
	assign sample_edge = st_r.hscc[dlr_pkg::CPOL_BIT] ? sclk_fall : sclk_rise;

	// Next state of the whole group
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = 1'b0;

		// Register writes; read-only bits are masked out
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				dlr_pkg::OFS_EQ_CTL: st_nxt.eq_ctl = reg_req_i.wdata;
				dlr_pkg::OFS_MCLK:   st_nxt.mclk = reg_req_i.wdata & dlr_pkg::MCLK_WMASK;
				dlr_pkg::OFS_LINK:   st_nxt.link = reg_req_i.wdata;
				dlr_pkg::OFS_HSCC:   st_nxt.hscc = reg_req_i.wdata;
				dlr_pkg::OFS_FLOOR:  st_nxt.floor = reg_req_i.wdata;
				default:             st_nxt.ack = 1'b0;
			endcase
			st_nxt.ack = 1'b1;
		end

		// Register reads; unmapped offsets return zero
		if (reg_req_i.rd) begin
			st_nxt.ack = 1'b1;
			case (reg_req_i.addr)
				dlr_pkg::OFS_EQ_CTL:   st_nxt.rdata = st_r.eq_ctl;
				dlr_pkg::OFS_STRAP:    st_nxt.rdata = {st_r.one_done, st_r.strap_one,
					st_r.zero_done, st_r.strap_zero};
				dlr_pkg::OFS_MCLK:     st_nxt.rdata = st_r.mclk;
				dlr_pkg::OFS_EQ_STATE: st_nxt.rdata = {2'h0, port_one_access_select_i
					? equalizer_state_p1_i : equalizer_state_p0_i};
				dlr_pkg::OFS_LINK:     st_nxt.rdata = st_r.link;
				dlr_pkg::OFS_HSCC:     st_nxt.rdata = st_r.hscc;
				dlr_pkg::OFS_FLOOR:    st_nxt.rdata = st_r.floor;
				default:               st_nxt.rdata = 8'h00;
			endcase
		end

		// Restart fires once per rising edge of the stored bit, on both ports,
		// so the host must clear it before another restart can be requested
		st_nxt.restart_d = st_r.eq_ctl[dlr_pkg::EQ_RESTART_BIT];
		st_nxt.restart_pls = {2{st_r.eq_ctl[dlr_pkg::EQ_RESTART_BIT]
			& ~st_r.restart_d}};

		// Strap decode: wait for pins to settle, then latch zero, then one
		case (st_r.strap_st)
			dlr_pkg::STRAP_SETTLE: begin
				if (st_r.settle_cnt == 6'(dlr_pkg::STRAP_SETTLE_CYC - 1)) begin
					st_nxt.strap_st = dlr_pkg::STRAP_ZERO;
				end else begin
					st_nxt.settle_cnt = st_r.settle_cnt + 6'h01;
				end
			end
			dlr_pkg::STRAP_ZERO: begin
				st_nxt.strap_zero = strap_zero_level_i;
				st_nxt.zero_done = 1'b1;
				st_nxt.strap_st = dlr_pkg::STRAP_ONE;
			end
			dlr_pkg::STRAP_ONE: begin
				st_nxt.strap_one = strap_one_level_i;
				st_nxt.one_done = 1'b1;
				st_nxt.strap_st = dlr_pkg::STRAP_IDLE;
			end
			dlr_pkg::STRAP_IDLE: st_nxt.strap_st = dlr_pkg::STRAP_IDLE;
			default: st_nxt.strap_st = dlr_pkg::STRAP_SETTLE;
		endcase

		// Link lock: acquisition wins over a same-cycle error
		if (link_acquire_i) begin
			st_nxt.lock = 1'b1;
			st_nxt.err_cnt = 4'h0;
		end else if (link_err && st_r.lock) begin
			if (st_r.link[dlr_pkg::LINK_EN_BIT]) begin
				if (err_inc >= {1'b0, st_r.link[dlr_pkg::LINK_THR_LSB +: 4]}) begin
					st_nxt.lock = 1'b0;
					st_nxt.err_cnt = 4'h0;
				end else begin
					st_nxt.err_cnt = err_inc[3:0];
				end
			end else begin
				st_nxt.lock = 1'b0;
				st_nxt.err_cnt = 4'h0;
			end
		end

		// SPI edges and the reverse-mode output driver
		st_nxt.sclk_d = spi_sclk_i;
		st_nxt.launch = launch_edge;
		st_nxt.sample = sample_edge;
		if (bc_dec.spi_reverse && launch_edge) begin
			st_nxt.miso = spi_miso_data_i;
		end
		// Only drive in reverse SPI; bused setups release the line when deselected
		if (bc_dec.spi_reverse) begin
			st_nxt.miso_oe_n = st_r.hscc[dlr_pkg::MISO_MODE_BIT] & spi_ss_n_i;
		end else begin
			st_nxt.miso_oe_n = 1'b1;
		end
	end

	// Register the state
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.eq_ctl <= dlr_pkg::EQ_CTL_RST;
			st_r.mclk <= dlr_pkg::MCLK_RST;
			st_r.link <= dlr_pkg::LINK_RST;
			st_r.hscc <= dlr_pkg::HSCC_RST;
			st_r.floor <= dlr_pkg::FLOOR_RST;
			st_r.strap_st <= dlr_pkg::STRAP_SETTLE;
			st_r.miso_oe_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign reg_rdata_o = st_r.rdata;
	assign reg_ack_o = st_r.ack;
	assign link_lock_o = st_r.lock;
	assign spi_launch_o = st_r.launch;
	assign spi_sample_o = st_r.sample;
	assign spi_miso_o = st_r.miso;
	assign spi_miso_oe_n_o = st_r.miso_oe_n;
endmodule

// *** sim/dlr_regs_sva.sv ***
// Port assertions for the link, equalizer and back-channel register group
`timescale 1ns/1ns
module dlr_regs_sva (
	// Clock and reset
	input wire logic                  sys_clk_i,
	input wire logic                  rst_i,
	// Register port and equalizer
	input wire dlr_pkg::dlr_reg_req_s reg_req_i,
	input wire logic [1:0]            equalizer_restart_o,
	input wire logic                  floor_active_o,
	input wire logic [3:0]            equalizer_start_level_o,
	// Link integrity
	input wire logic                  pix_tick_i, err_clk0_i, err_clk1_i,
	input wire logic                  err_data_channel_i, link_acquire_i, link_lock_o,
	// Back channel and serial port
	input wire logic                  spi_sclk_i,
	input wire dlr_pkg::dlr_bc_dec_s  bc_mode_o,
	input wire logic                  spi_launch_o, spi_sample_o, spi_miso_oe_n_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// An error that the counter may take this cycle
	wire err_seen = pix_tick_i && (err_clk0_i || err_clk1_i || err_data_channel_i);
	// Restart writes and the pulse they cause
	sequence s_eq_wr(logic hi);
		reg_req_i.wr && reg_req_i.addr == 8'h35 && reg_req_i.wdata[6] == hi;
	endsequence
	sequence s_pulse; equalizer_restart_o == 2'b11 ##1 equalizer_restart_o == 2'b00; endsequence
	property p_restart; s_eq_wr(1'b0) ##2 s_eq_wr(1'b1) |-> ##2 s_pulse; endproperty
	a_restart: assert property (p_restart) else $error("restart pulse missing");
	property p_pair; equalizer_restart_o[0] == equalizer_restart_o[1]; endproperty
	a_pair: assert property (p_pair) else $error("restart differs between ports");
	property p_floor; !floor_active_o |-> equalizer_start_level_o == 4'h0; endproperty
	a_floor: assert property (p_floor) else $error("floor level without override");
	property p_drop; $fell(link_lock_o) |-> $past(err_seen) || $past(err_seen, 2); endproperty
	a_drop: assert property (p_drop) else $error("lock lost without error");
	property p_gain; $rose(link_lock_o) |-> $past(link_acquire_i); endproperty
	a_gain: assert property (p_gain) else $error("lock regained without acquire");
	property p_oe; $fell(spi_miso_oe_n_o) |-> $past(bc_mode_o.spi_reverse); endproperty
	a_oe: assert property (p_oe) else $error("data out driven outside reverse mode");
	// Pulse stands one cycle after the edge that saw the new serial clock level
	property p_edge;
		spi_launch_o || spi_sample_o |-> $past(spi_sclk_i) != $past(spi_sclk_i, 2);
	endproperty
	a_edge: assert property (p_edge) else $error("edge pulse without clock change");
	property p_excl; !(spi_launch_o && spi_sample_o); endproperty
	a_excl: assert property (p_excl) else $error("launch and sample together");
	property p_rev; bc_mode_o.spi_reverse |-> bc_mode_o.spi_mode; endproperty
	a_rev: assert property (p_rev) else $error("reverse outside serial mode");
endmodule
bind dlr_regs dlr_regs_sva u_sva (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
	.equalizer_restart_o(equalizer_restart_o), .floor_active_o(floor_active_o),
	.equalizer_start_level_o(equalizer_start_level_o), .pix_tick_i(pix_tick_i),
	.err_clk0_i(err_clk0_i), .err_clk1_i(err_clk1_i), .err_data_channel_i(err_data_channel_i),
	.link_acquire_i(link_acquire_i), .link_lock_o(link_lock_o), .spi_sclk_i(spi_sclk_i),
	.bc_mode_o(bc_mode_o), .spi_launch_o(spi_launch_o), .spi_sample_o(spi_sample_o),
	.spi_miso_oe_n_o(spi_miso_oe_n_o)
);

// *** sim/dlr_host_model.sv ***
// Host controller model on the register port
`timescale 1ns/1ns
module dlr_host_model (
	// Clock and answer
	input  wire logic            sys_clk_i,
	input  wire logic [7:0]      reg_rdata_i,
	input  wire logic            reg_ack_i,
	// Request
	output dlr_pkg::dlr_reg_req_s reg_req_o
);
	// Idle until the bench asks for a transfer
	initial reg_req_o = '0;
	// One-cycle strobe; answer taken in the ack cycle, no retry
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] rd,
		output logic ak);
		@(posedge sys_clk_i);
		#5 reg_req_o = {w, !w, a, d};
		@(posedge sys_clk_i);
		#5 reg_req_o = '0;
		rd = reg_rdata_i;
		ak = reg_ack_i;
	endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the register group
`timescale 1ns/1ns
module testbench;
	// Bench signals
	logic                  sys_clk_i, rst_i, psel, ref_tk, pix_tk, acq, sclk, ss_n, miso_d;
	logic [5:0]            eq0, eq1;
	logic [2:0]            st0, st1, pout, errs;
	logic [1:0]            pin, rs;
	logic [3:0]            lvl;
	logic [7:0]            rdat, rd;
	logic                  ack, ak, fl, mck, osc, lock, lau, smp, miso, oe_n;
	dlr_pkg::dlr_reg_req_s req;
	dlr_pkg::dlr_bc_dec_s  bc;
	int                    miscompares = 0;
	int                    checks = 0;

	dlr_host_model host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdat), .reg_ack_i(ack), .reg_req_o(req));
	dlr_regs dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdat),
		.reg_ack_o(ack), .port_one_access_select_i(psel), .equalizer_state_p0_i(eq0),
		.equalizer_state_p1_i(eq1), .equalizer_restart_o(rs), .floor_active_o(fl),
		.equalizer_start_level_o(lvl), .strap_zero_level_i(st0), .strap_one_level_i(st1),
		.ref_tick_i(ref_tk), .pll_output_code_i(pout), .pll_input_code_i(pin),
		.osc_tick_o(osc), .mclk_tick_o(mck), .pix_tick_i(pix_tk), .err_clk0_i(errs[0]),
		.err_clk1_i(errs[1]), .err_data_channel_i(errs[2]), .link_acquire_i(acq),
		.link_lock_o(lock), .spi_sclk_i(sclk), .spi_ss_n_i(ss_n), .spi_miso_data_i(miso_d),
		.bc_mode_o(bc), .spi_launch_o(lau), .spi_sample_o(smp), .spi_miso_o(miso),
		.spi_miso_oe_n_o(oe_n)
	);
	// 20 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// A used-up wait bound ends the run as a failure
	task automatic guard(input int k);
		if (k >= 300) begin
			miscompares++;
			print_verdict();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#5;
	endtask
	task automatic wr(input logic [7:0] a, d);
		host.xfer(1'b1, a, d, rd, ak);
	endtask
	task automatic rdchk(input logic [7:0] a, exp);
		host.xfer(1'b0, a, 8'h00, rd, ak);
		chk({7'h00, ak}, 8'h01);
		chk(rd, exp);
	endtask
	task automatic t_regs();
		rdchk(8'h35, 8'h00);
		rdchk(8'h3A, 8'h00);
		rdchk(8'h41, 8'h03);
		rdchk(8'h43, 8'h00);
		rdchk(8'h45, 8'h88);
		rdchk(8'h5A, 8'h00);
		wr(8'h3A, 8'hFF);
		rdchk(8'h3A, 8'hF7);
		eq0 = 6'h2A;
		eq1 = 6'h15;
		wr(8'h3B, 8'hFF);
		rdchk(8'h3B, 8'h2A);
		psel = 1'b1;
		rdchk(8'h3B, 8'h15);
		psel = 1'b0;
	endtask
	// Restart from either port selection, then the floor gating
	task automatic t_eq();
		repeat (2) begin
			wr(8'h35, 8'h00);
			wr(8'h35, 8'h40);
			tick(1);
			chk({6'h00, rs}, 8'h03);
			tick(1);
			chk({6'h00, rs}, 8'h00);
			psel = ~psel;
		end
		wr(8'h45, 8'h05);
		wr(8'h35, 8'h10);
		chk({fl, 3'h0, lvl}, 8'h00);
		wr(8'h35, 8'h30);
		chk({fl, 3'h0, lvl}, 8'h85);
		wr(8'h35, 8'h20);
		chk({fl, 3'h0, lvl}, 8'h00);
	endtask
	task automatic err(input int i);
		errs = 3'b001 << i;
		tick(1);
		errs = 3'b000;
		tick(2);
	endtask
	task automatic acquire();
		acq = 1'b1;
		tick(1);
		acq = 1'b0;
		tick(1);
		chk({7'h00, lock}, 8'h01);
	endtask
	// Each error on a different channel so all three are counted
	task automatic t_link();
		wr(8'h41, 8'h13);
		acquire();
		err(0);
		err(1);
		chk({7'h00, lock}, 8'h01);
		err(2);
		chk({7'h00, lock}, 8'h00);
		wr(8'h41, 8'h03);
		acquire();
		// Errors off the pixel-rate enable must not be counted
		pix_tk = 1'b0;
		err(0);
		chk({7'h00, lock}, 8'h01);
		pix_tk = 1'b1;
		err(1);
		chk({7'h00, lock}, 8'h00);
	endtask
	task automatic edge_chk(input logic v, input logic [1:0] exp);
		logic [1:0] seen;
		seen = 2'b00;
		sclk = v;
		repeat (4) begin
			tick(1);
			seen = seen | {lau, smp};
		end
		chk({6'h00, seen}, {6'h00, exp});
	endtask
	task automatic t_spi();
		int c;
		logic hs;
		for (c = 0; c < 8; c++) begin
			wr(8'h43, {5'h00, c[2:0]});
			hs = c[2] ? c[1] : (c[1:0] != 2'h0);
			chk({5'h00, bc[5:3]}, {5'h00, hs, c[2], c[0] & c[2]});
			if (!c[2]) chk({5'h00, bc.gpio_lanes}, c == 0 ? 8'h01 : 8'h01 << (c - 1));
		end
		miso_d = 1'b1;
		wr(8'h43, 8'h15);
		tick(2);
		chk({7'h00, oe_n}, 8'h01);
		ss_n = 1'b0;
		tick(2);
		chk({7'h00, oe_n}, 8'h00);
		edge_chk(1'b1, 2'b01);
		edge_chk(1'b0, 2'b10);
		chk({7'h00, miso}, 8'h01);
		ss_n = 1'b1;
		wr(8'h43, 8'h0D);
		tick(2);
		chk({7'h00, oe_n}, 8'h00);
		miso_d = 1'b0;
		edge_chk(1'b1, 2'b10);
		edge_chk(1'b0, 2'b01);
		chk({7'h00, miso}, 8'h00);
		wr(8'h43, 8'h04);
		tick(2);
		chk({7'h00, oe_n}, 8'h01);
	endtask
	// Second full period is measured, so a count left from the old ratio does not matter
	task automatic period(input logic [7:0] exp, input logic sel);
		int n;
		int k;
		k = 0;
		repeat (2) begin
			n = 0;
			while ((sel ? osc : mck) !== 1'b1 && k < 300) begin
				tick(1);
				k++;
			end
			do begin
				tick(1);
				n++;
				k++;
			end while ((sel ? osc : mck) !== 1'b1 && k < 300);
		end
		guard(k);
		chk(n[7:0], exp);
	endtask
	task automatic t_mclk();
		int c;
		for (c = 0; c < 8; c++) begin
			wr(8'h3A, {1'b1, c[2:0], 4'h4});
			period(8'h20 >> (c < 4 ? c : 4 + c[1]), 1'b0);
		end
		for (c = 0; c < 4; c++) begin
			wr(8'h3A, {4'hE, 2'b01, c[1:0]});
			period(8'h01 << c, 1'b0);
			period(8'h01 << c, 1'b1);
		end
		pout = 3'h2;
		pin = 2'h1;
		wr(8'h3A, 8'h00);
		period(8'h10, 1'b0);
		wr(8'h3A, 8'hB0);
		period(8'h08, 1'b0);
		period(8'h02, 1'b1);
	endtask
	// Main sequence
	initial begin
		{psel, acq, sclk, miso_d, errs, eq0, eq1, pout, pin} = '0;
		ss_n = 1'b1;
		ref_tk = 1'b1;
		pix_tk = 1'b1;
		st0 = 3'h2;
		st1 = 3'h5;
		rst_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
		#5 rst_i = 1'b0;
		rdchk(8'h37, 8'h00);
		t_regs();
		t_eq();
		t_link();
		t_spi();
		t_mclk();
		rdchk(8'h37, 8'hDA);
		print_verdict();
	end
endmodule
